//--- pkg/fault_state_defs.svh
// fault_state_defs.svh: offsets, field positions, reset values, timing.
// assumes a 10 MHz system clock; times are given in ms or us.
`ifndef FAULT_STATE_DEFS_SVH
`define FAULT_STATE_DEFS_SVH

// clock rate in kHz
`define CLK_KHZ          10000

// timing figures
`define T_DEB_MS         20
`define T_CFG_MS         3000
`define T_SAFE_MS        10000
`define T_IDLE_MS        20000
// half periods of the 1.5 Hz and 6 Hz blink
`define T_SLOW_HALF_US   333333
`define T_FAST_HALF_US   83333

// counter width, enough for the 20 s idle count
`define CNT_W            28

// register byte offsets
`define OFS_CTRL         8'h00
`define OFS_STAT         8'h04
`define OFS_HART         8'h08
`define OFS_PROT         8'h0C

// field positions
`define CTRL_HI_BIT      0
`define HART_MALF_BIT    7
`define HART_MORE_BIT    4
`define SB_ERR_BIT       7

// reset and fixed values
`define CTRL_HI_RST      1'b0
`define DDA_ERR_CODE     32'h45313032
`define STAT_ERR_CODE    8'h01
`define STAT_OK_CODE     8'h00

`endif

//--- pkg/fault_state_pkg.sv
// fault_state_pkg: types shared by the fault signalling block.
// assumes fault_state_defs.svh for all numeric constants.
`include "fault_state_defs.svh"
package fault_state_pkg;

	typedef enum logic [2:0] {
		CUR_LEVEL,
		CUR_FAULT_LO,
		CUR_FAULT_HI,
		CUR_RANGE_CFG,
		CUR_FAULT_CFG
	} loop_cur_t;

	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_CFG_RANGE,
		MODE_CFG_FAULT,
		MODE_SAFE
	} mode_t;

	// low five bits line up with the device-specific status byte
	typedef struct packed {
		logic float_missing;
		logic undervolt;
		logic too_many_err;
		logic no_meas;
		logic sensor_param_bad;
		logic proto_param_bad;
	} err_in_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		logic [7:0]  hart_status;
		logic [7:0]  hart_dev;
		logic [31:0] dda_field;
		logic [7:0]  status_code;
		logic [7:0]  sb_status;
		logic        diag_err;
	} proto_out_t;

	typedef struct packed {
		mode_t      mode;
		mode_t      back;
		logic [1:0] btn_stab;
		logic [`CNT_W-1:0] deb_cnt;
		logic [`CNT_W-1:0] hold_cnt;
		logic [`CNT_W-1:0] idle_cnt;
		logic [`CNT_W-1:0] blink_cnt;
		logic       led;
		logic       hi_sel;
		loop_cur_t  loop_cur;
		proto_out_t po;
		logic [31:0] rdata;
	} state_t;

endpackage : fault_state_pkg

//--- hw/fault_state_signalling.sv
// fault_state_signalling: loop fault current, button test sequence,
// led blink and protocol error encoding for a level sensor.
// assumes buttons and error inputs are synchronous to clk_sys.
`include "fault_state_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module fault_state_signalling #(
	parameter int unsigned DEB_CYC  = `T_DEB_MS * `CLK_KHZ,
	parameter int unsigned CFG_CYC  = `T_CFG_MS * `CLK_KHZ,
	parameter int unsigned SAFE_CYC = `T_SAFE_MS * `CLK_KHZ,
	parameter int unsigned IDLE_CYC = `T_IDLE_MS * `CLK_KHZ,
	parameter int unsigned SLOW_CYC = `T_SLOW_HALF_US * (`CLK_KHZ / 1000),
	parameter int unsigned FAST_CYC = `T_FAST_HALF_US * (`CLK_KHZ / 1000)
) (
	input  wire logic                        clk_sys,
	input  wire logic                        rst_n,
	input  wire fault_state_pkg::reg_req_t   req,
	output var  logic [31:0]                 rdata,
	input  wire logic [1:0]                  btn,
	input  wire fault_state_pkg::err_in_t    err,
	input  wire logic [15:0]                 level,
	output var  fault_state_pkg::loop_cur_t  loop_cur,
	output var  logic                        led,
	output var  fault_state_pkg::proto_out_t proto
);
	import fault_state_pkg::*;

	localparam logic [`CNT_W-1:0] DEB_LIM  = `CNT_W'(DEB_CYC - 1);
	localparam logic [`CNT_W-1:0] CFG_LIM  = `CNT_W'(CFG_CYC - 1);
	localparam logic [`CNT_W-1:0] SAFE_LIM = `CNT_W'(SAFE_CYC - 1);
	localparam logic [`CNT_W-1:0] IDLE_LIM = `CNT_W'(IDLE_CYC - 1);
	localparam logic [`CNT_W-1:0] SLOW_LIM = `CNT_W'(SLOW_CYC - 1);
	localparam logic [`CNT_W-1:0] FAST_LIM = `CNT_W'(FAST_CYC - 1);

	logic   rst_meta_ff;
	logic   rst_sync_n_ff;
	state_t s_ff;
	state_t nxt_s;
	logic   pressed;
	logic   err_any;
	logic [`CNT_W-1:0] half_lim;

	// saturating counter step
	function automatic logic [`CNT_W-1:0] sat_inc(
		input logic [`CNT_W-1:0] v
	);
		sat_inc = (v == '1) ? v : v + 1'b1;
	endfunction : sat_inc

	// fault level from selection and supply
	function automatic loop_cur_t fault_cur(
		input logic hi,
		input logic low_supply
	);
		fault_cur = (hi && !low_supply) ? CUR_FAULT_HI : CUR_FAULT_LO;
	endfunction : fault_cur

	// reset release through two flops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_ff   <= 1'b0;
			rst_sync_n_ff <= 1'b0;
		end else begin
			rst_meta_ff   <= 1'b1;
			rst_sync_n_ff <= rst_meta_ff;
		end
	end

	assign pressed = |s_ff.btn_stab;
	assign err_any = |err;

	always_comb begin
		nxt_s    = s_ff;
		half_lim = SLOW_LIM;

		if (btn != s_ff.btn_stab) begin
			if (s_ff.deb_cnt >= DEB_LIM) begin
				nxt_s.btn_stab = btn;
				nxt_s.deb_cnt  = '0;
			end else begin
				nxt_s.deb_cnt = s_ff.deb_cnt + 1'b1;
			end
		end else begin
			nxt_s.deb_cnt = '0;
		end

		if (!pressed || nxt_s.btn_stab != s_ff.btn_stab) begin
			nxt_s.hold_cnt = '0;
		end else begin
			nxt_s.hold_cnt = sat_inc(s_ff.hold_cnt);
		end

		if (pressed) begin
			nxt_s.idle_cnt = '0;
		end else begin
			nxt_s.idle_cnt = sat_inc(s_ff.idle_cnt);
		end

		unique case (s_ff.mode)
			MODE_RUN: begin
				if (pressed && s_ff.hold_cnt >= CFG_LIM) begin
					if (&s_ff.btn_stab) begin
						nxt_s.mode = MODE_CFG_FAULT;
					end else begin
						nxt_s.mode = MODE_CFG_RANGE;
					end
					nxt_s.back = nxt_s.mode;
				end
			end
			MODE_CFG_RANGE, MODE_CFG_FAULT: begin
				if (pressed && s_ff.hold_cnt >= SAFE_LIM) begin
					nxt_s.mode = MODE_SAFE;
				end else if (!pressed && s_ff.idle_cnt >= IDLE_LIM) begin
					nxt_s.mode = MODE_RUN;
				end
			end
			MODE_SAFE: begin
				if (!pressed) begin
					nxt_s.mode = s_ff.back;
				end
			end
		endcase

		unique case (nxt_s.mode)
			MODE_RUN: begin
				nxt_s.loop_cur = err_any
					? fault_cur(s_ff.hi_sel, err.undervolt) : CUR_LEVEL;
			end
			MODE_CFG_RANGE: nxt_s.loop_cur = CUR_RANGE_CFG;
			MODE_CFG_FAULT: nxt_s.loop_cur = CUR_FAULT_CFG;
			MODE_SAFE: begin
				nxt_s.loop_cur = fault_cur(s_ff.hi_sel, err.undervolt);
			end
		endcase

		if (nxt_s.mode == MODE_SAFE) begin
			half_lim = FAST_LIM;
		end
		if (nxt_s.mode == MODE_RUN
			|| nxt_s.loop_cur == CUR_FAULT_LO) begin
			nxt_s.led       = 1'b0;
			nxt_s.blink_cnt = '0;
		end else if (s_ff.blink_cnt >= half_lim) begin
			nxt_s.led       = !s_ff.led;
			nxt_s.blink_cnt = '0;
		end else begin
			nxt_s.blink_cnt = s_ff.blink_cnt + 1'b1;
		end

		nxt_s.po.hart_status = '0;
		nxt_s.po.hart_status[`HART_MALF_BIT] = err_any;
		nxt_s.po.hart_status[`HART_MORE_BIT] = err_any;
		nxt_s.po.hart_dev = {3'h0, err[4:0]};
		nxt_s.po.dda_field = err_any ? `DDA_ERR_CODE : {16'h0000, level};
		nxt_s.po.status_code = err_any ? `STAT_ERR_CODE : `STAT_OK_CODE;
		nxt_s.po.sb_status = '0;
		nxt_s.po.sb_status[`SB_ERR_BIT] = err_any;
		nxt_s.po.diag_err = err_any;

		// register port
		nxt_s.rdata = '0;
		if (req.wr && req.addr == `OFS_CTRL) begin
			nxt_s.hi_sel = req.wdata[`CTRL_HI_BIT];
		end
		if (req.rd) begin
			unique case (req.addr)
				`OFS_CTRL: nxt_s.rdata = {31'h0, s_ff.hi_sel};
				`OFS_STAT: nxt_s.rdata = {16'h0, 2'h0, s_ff.btn_stab,
					s_ff.led, s_ff.loop_cur, s_ff.mode, err};
				`OFS_HART: nxt_s.rdata = {16'h0, s_ff.po.hart_status,
					s_ff.po.hart_dev};
				`OFS_PROT: nxt_s.rdata = {16'h0, s_ff.po.status_code,
					s_ff.po.sb_status};
				default:   nxt_s.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n_ff) begin
		if (!rst_sync_n_ff) begin
			s_ff        <= '0;
			s_ff.hi_sel <= `CTRL_HI_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign rdata    = s_ff.rdata;
	assign loop_cur = s_ff.loop_cur;
	assign led      = s_ff.led;
	assign proto    = s_ff.po;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_sync_n_ff);

	property p_run_fault;
		(s_ff.mode == MODE_RUN && err_any) ##1 (s_ff.mode == MODE_RUN)
			|-> s_ff.loop_cur inside {CUR_FAULT_LO, CUR_FAULT_HI};
	endproperty
	a_run_fault: assert property (p_run_fault)
		else $error("fault current missing in run mode");

	property p_low_supply;
		err.undervolt |=> s_ff.loop_cur != CUR_FAULT_HI;
	endproperty
	a_low_supply: assert property (p_low_supply)
		else $error("high fault current under low supply");

	property p_range_entry;
		($changed(s_ff.mode) && s_ff.mode == MODE_CFG_RANGE
			&& $past(s_ff.mode) == MODE_RUN)
			|-> $onehot($past(s_ff.btn_stab))
			&& $past(s_ff.hold_cnt) >= CFG_LIM
			&& s_ff.loop_cur == CUR_RANGE_CFG;
	endproperty
	a_range_entry: assert property (p_range_entry)
		else $error("bad entry to range config");

	property p_fault_entry;
		($changed(s_ff.mode) && s_ff.mode == MODE_CFG_FAULT
			&& $past(s_ff.mode) == MODE_RUN)
			|-> $past(s_ff.btn_stab) == 2'b11
			&& s_ff.loop_cur == CUR_FAULT_CFG;
	endproperty
	a_fault_entry: assert property (p_fault_entry)
		else $error("bad entry to fault config");

	property p_safe_entry;
		($changed(s_ff.mode) && s_ff.mode == MODE_SAFE)
			|-> $past(s_ff.hold_cnt) >= SAFE_LIM
			&& s_ff.loop_cur inside {CUR_FAULT_LO, CUR_FAULT_HI};
	endproperty
	a_safe_entry: assert property (p_safe_entry)
		else $error("safe state entered early or wrong current");

	property p_safe_dark;
		(s_ff.mode == MODE_SAFE && s_ff.loop_cur == CUR_FAULT_LO)
			|-> !s_ff.led;
	endproperty
	a_safe_dark: assert property (p_safe_dark)
		else $error("led lit at low fault current");

	property p_release;
		(s_ff.mode == MODE_SAFE && !pressed)
			|=> s_ff.mode == $past(s_ff.back);
	endproperty
	a_release: assert property (p_release)
		else $error("release did not return to config");

	property p_idle_exit;
		(s_ff.mode inside {MODE_CFG_RANGE, MODE_CFG_FAULT})
			|-> s_ff.idle_cnt <= IDLE_LIM;
	endproperty
	a_idle_exit: assert property (p_idle_exit)
		else $error("config mode outlived idle limit");

	property p_hart_flags;
		err_any |=> s_ff.po.hart_status[`HART_MALF_BIT]
			&& s_ff.po.hart_status[`HART_MORE_BIT];
	endproperty
	a_hart_flags: assert property (p_hart_flags)
		else $error("hart flags not set on error");

	property p_dda_code;
		err_any |=> s_ff.po.dda_field == `DDA_ERR_CODE
			&& s_ff.po.status_code == `STAT_ERR_CODE;
	endproperty
	a_dda_code: assert property (p_dda_code)
		else $error("error codes missing on error");

	property p_slow_blink;
		(s_ff.mode inside {MODE_CFG_RANGE, MODE_CFG_FAULT} && $changed(s_ff.led))
			|-> $past(s_ff.blink_cnt) >= SLOW_LIM;
	endproperty
	a_slow_blink: assert property (p_slow_blink)
		else $error("config led toggled off the slow rate");

	property p_fast_blink;
		(s_ff.mode == MODE_SAFE && $rose(s_ff.led))
			|-> $past(s_ff.blink_cnt) >= FAST_LIM && s_ff.loop_cur == CUR_FAULT_HI;
	endproperty
	a_fast_blink: assert property (p_fast_blink)
		else $error("safe led lit off the fast rate");

	property p_hart_clean;
		!err_any |=> s_ff.po.hart_status == 8'h00;
	endproperty
	a_hart_clean: assert property (p_hart_clean)
		else $error("hart flags set without error");

	property p_param_bits;
		(err.proto_param_bad || err.sensor_param_bad)
			|=> s_ff.po.hart_dev[1:0] == $past({err.sensor_param_bad, err.proto_param_bad});
	endproperty
	a_param_bits: assert property (p_param_bits)
		else $error("parameter status bits wrong");

	property p_meas_bits;
		(err.no_meas || err.too_many_err || err.undervolt)
			|=> s_ff.po.hart_dev[4:2]
				== $past({err.undervolt, err.too_many_err, err.no_meas});
	endproperty
	a_meas_bits: assert property (p_meas_bits)
		else $error("measurement status bits wrong");

	property p_sb_err;
		err_any |=> s_ff.po.sb_status[`SB_ERR_BIT];
	endproperty
	a_sb_err: assert property (p_sb_err)
		else $error("status byte error bit missing");

	property p_diag;
		err_any |=> s_ff.po.diag_err;
	endproperty
	a_diag: assert property (p_diag)
		else $error("diagnostic indication missing");

	property p_err_clear;
		!err_any |=> !s_ff.po.diag_err && s_ff.po.status_code == `STAT_OK_CODE
			&& s_ff.po.dda_field == {16'h0000, $past(level)};
	endproperty
	a_err_clear: assert property (p_err_clear)
		else $error("error reporting did not clear");

	property p_err_reach;
		(err_any && s_ff.mode == MODE_RUN) |=> s_ff.loop_cur != CUR_LEVEL;
	endproperty
	a_err_reach: assert property (p_err_reach)
		else $error("level current kept after error");

	property p_debounce;
		$changed(s_ff.btn_stab)
			|-> $past(s_ff.deb_cnt) >= DEB_LIM && s_ff.hold_cnt == '0;
	endproperty
	a_debounce: assert property (p_debounce)
		else $error("button adopted early or hold not restarted");

	property p_blink_run;
		(s_ff.mode == MODE_RUN) |-> !s_ff.led && s_ff.blink_cnt == '0;
	endproperty
	a_blink_run: assert property (p_blink_run)
		else $error("blink divider running in run mode");

endmodule : fault_state_signalling

`default_nettype wire

//--- sim/loop_host_model.sv
// loop_host_model: far-side monitor reading loop current and status.
// assumes the signalling block outputs, same clock and reset.
`timescale 1ns/1ps
`default_nettype none
module loop_host_model (
	input  wire logic                        clk_sys,
	input  wire logic                        rst_n,
	input  wire fault_state_pkg::loop_cur_t  loop_cur,
	input  wire fault_state_pkg::proto_out_t proto,
	output var  logic                        host_malf
);
	import fault_state_pkg::*;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			host_malf <= 1'b0;
		end else begin
			host_malf <= proto.hart_status[7] | (proto.status_code != 8'h00) |
				(loop_cur == CUR_FAULT_LO) | (loop_cur == CUR_FAULT_HI);
		end
	end
endmodule : loop_host_model
`default_nettype wire

//--- sim/fault_state_signalling_bench.sv
// fault_state_signalling_bench: random error patterns and button sequences.
// assumes shortened counts: debounce 4, config 30, safe 100, idle 200.
`timescale 1ns/1ps
`default_nettype none
module fault_state_signalling_bench;
	import fault_state_pkg::*;
	logic        clk_sys;
	logic        rst_n;
	reg_req_t    req;
	logic [31:0] rdata;
	logic [1:0]  btn;
	err_in_t     err;
	logic [15:0] level;
	loop_cur_t   loop_cur;
	logic        led;
	proto_out_t  proto;
	logic        host_malf;
	int          error_cnt;
	int          checked;
	int          tog;

	// shortened counts keep the run short
	localparam int unsigned DEB_SIM  = 4;
	localparam int unsigned CFG_SIM  = 30;
	localparam int unsigned SAFE_SIM = 100;
	localparam int unsigned IDLE_SIM = 200;
	localparam int unsigned SLOW_SIM = 10;
	localparam int unsigned FAST_SIM = 3;

	fault_state_signalling #(.DEB_CYC(DEB_SIM), .CFG_CYC(CFG_SIM), .SAFE_CYC(SAFE_SIM),
		.IDLE_CYC(IDLE_SIM), .SLOW_CYC(SLOW_SIM), .FAST_CYC(FAST_SIM))
		dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
		.rdata(rdata), .btn(btn), .err(err), .level(level), .loop_cur(loop_cur),
		.led(led), .proto(proto));
	loop_host_model host_u (.clk_sys(clk_sys), .rst_n(rst_n), .loop_cur(loop_cur),
		.proto(proto), .host_malf(host_malf));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (exp !== got) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		req.wr <= 1'b0;
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk_sys);
		req.rd <= 1'b0;
		#1;
		d = rdata;
	endtask : bus_rd

	// bounded wait for a loop current, run ends if it never comes
	task automatic wait_cur(input loop_cur_t want, input int lim);
		int n;
		n = 0;
		while (loop_cur !== want && n < lim) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk("loop_cur", 32'(want), 32'(loop_cur));
		if (loop_cur !== want) finish_test();
	endtask : wait_cur

	task automatic blink(input int n);
		logic last;
		tog = 0;
		last = led;
		repeat (n) begin
			@(posedge clk_sys);
			#1;
			if (led !== last) tog++;
			last = led;
		end
	endtask : blink

	task automatic err_case(input err_in_t e, input logic hi);
		loop_cur_t   cur;
		logic [31:0] d;
		logic        bad;
		bad = |e;
		cur = !bad ? CUR_LEVEL : (hi && !e.undervolt) ? CUR_FAULT_HI : CUR_FAULT_LO;
		@(posedge clk_sys);
		err <= e;
		level <= 16'($urandom);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("loop_cur", 32'(cur), 32'(loop_cur));
		chk("hart_status", bad ? 32'h90 : 32'h0, 32'(proto.hart_status));
		chk("hart_dev", {27'h0, e[4:0]}, 32'(proto.hart_dev));
		chk("fill_field", bad ? 32'h45313032 : {16'h0, level}, proto.dda_field);
		chk("status_code", 32'(bad), 32'(proto.status_code));
		chk("status_byte", bad ? 32'h80 : 32'h0, 32'(proto.sb_status));
		chk("diag", 32'(bad), 32'(proto.diag_err));
		bus_rd(8'h08, d);
		chk("hart_reg", {16'h0, bad ? 8'h90 : 8'h00, 3'h0, e[4:0]}, d);
		bus_rd(8'h0C, d);
		chk("prot_reg", {16'h0, bad ? 8'h01 : 8'h00, bad ? 8'h80 : 8'h00}, d);
		bus_rd(8'h04, d);
		chk("stat_reg", {21'h0, cur, 2'b00, e}, d);
		chk("host_malf", 32'(bad), 32'(host_malf));
	endtask : err_case

	task automatic btn_seq(input logic [1:0] b, input logic hi);
		loop_cur_t cfg;
		loop_cur_t flt;
		cfg = (b == 2'b11) ? CUR_FAULT_CFG : CUR_RANGE_CFG;
		flt = hi ? CUR_FAULT_HI : CUR_FAULT_LO;
		bus_wr(8'h00, {31'h0, hi});
		@(posedge clk_sys);
		btn <= b;
		wait_cur(cfg, 45);
		blink(40);
		chk("slow_blink", 32'h1, 32'(tog >= 3 && tog <= 5));
		wait_cur(flt, 60);
		blink(30);
		chk("safe_blink", 32'h1, 32'(hi ? tog >= 8 : (tog == 0 && led === 1'b0)));
		@(posedge clk_sys);
		btn <= 2'b00;
		wait_cur(cfg, 15);
		wait_cur(CUR_LEVEL, 230);
		chk("level_field", {16'h0, level}, proto.dda_field);
		$display("button test %b done", b);
	endtask : btn_seq

	initial begin
		logic [31:0] d;
		err_in_t     e;
		logic        hi;
		rst_n = 1'b0;
		req = '0;
		btn = 2'b00;
		err = '0;
		level = 16'h0;
		error_cnt = 0;
		checked = 0;
		void'($urandom(32'h2202CE3C));
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		bus_rd(8'h00, d);
		chk("ctrl_reset", 32'h0, d);
		bus_rd(8'h40, d);
		chk("unmapped", 32'h0, d);
		for (int i = 0; i < 24; i++) begin
			hi = ~i[0];
			bus_wr(8'h00, {31'h0, hi});
			bus_rd(8'h00, d);
			chk("ctrl", {31'h0, hi}, d);
			e = (i < 6) ? err_in_t'(6'h01 << i) : err_in_t'(6'($urandom));
			err_case(e, hi);
			err_case('0, hi);
		end
		$display("error tests done");
		btn_seq(2'b01, 1'b1);
		btn_seq(2'b11, 1'b0);
		btn_seq(2'b10, 1'b0);
		// glitch shorter than the debounce is ignored
		@(posedge clk_sys);
		btn <= 2'b01;
		repeat (2) @(posedge clk_sys);
		btn <= 2'b00;
		repeat (8) @(posedge clk_sys);
		bus_rd(8'h04, d);
		chk("glitch_stat", 32'h0, d);
		// reset in mid config clears mode, led and selection
		bus_wr(8'h00, 32'h1);
		@(posedge clk_sys);
		btn <= 2'b01;
		wait_cur(CUR_RANGE_CFG, 45);
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b0;
		btn <= 2'b00;
		repeat (2) @(posedge clk_sys);
		#1;
		chk("reset_cur", 32'(CUR_LEVEL), 32'(loop_cur));
		chk("reset_led", 32'h0, 32'(led));
		@(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		bus_rd(8'h00, d);
		chk("reset_ctrl", 32'h0, d);
		bus_rd(8'h04, d);
		chk("reset_stat", 32'h0, d);
		$display("reset test done");
		finish_test();
	end
endmodule : fault_state_signalling_bench
`default_nettype wire
